//--- cbl_top.sv
`include "cbl_cfg.svh"

module cbl_top import cbl_pkg::*; (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        hall_sense_a,
	input  wire logic        hall_sense_b,
	input  wire logic        hall_sense_c,
	input  wire logic        brake_timing_node,
	input  wire logic        supply_low,
	input  wire logic        pwm_tick,
	input  wire logic        pwm_on,
	output logic             low_side_drive_a,
	output logic             low_side_drive_b,
	output logic             low_side_drive_c,
	output logic             high_side_drive_a_n,
	output logic             high_side_drive_b_n,
	output logic             high_side_drive_c_n,
	output logic             tach_pulse,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// pin synchronisers: three flops, change taken when 2nd and 3rd agree
	logic [4:0] pin_raw;
	logic [4:0] s1_q, s2_q, s3_q;
	logic [4:0] pin_ok_q, pin_ok_d;

	assign pin_raw = {supply_low, brake_timing_node,
		hall_sense_c, hall_sense_b, hall_sense_a};

	always_comb begin
		pin_ok_d = pin_ok_q;
		for (int i = 0; i < 5; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				pin_ok_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q     <= 5'h08;
			s2_q     <= 5'h08;
			s3_q     <= 5'h08;
			pin_ok_q <= 5'h08;
		end else begin
			s1_q     <= pin_raw;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			pin_ok_q <= pin_ok_d;
		end
	end

	logic [2:0] hall_now;
	logic       brake_pin;
	logic       uvlo;
	assign hall_now  = pin_ok_q[2:0];
	assign brake_pin = ~pin_ok_q[3];
	assign uvlo      = pin_ok_q[4];

	// software registers
	cbl_ctrl_t   ctrl_q, ctrl_d;
	logic [15:0] tach_w_q, tach_w_d;
	logic        brake;
	assign brake = ctrl_q.brake | brake_pin;

	// position latch, blanking and tachometer
	cbl_latch_st_t st_q, st_d;
	logic [2:0]  pos_q, pos_d;
	logic [1:0]  blank_q, blank_d;
	logic        tach_q, tach_d;
	logic [15:0] tach_cnt_q, tach_cnt_d;
	logic        load;

	always_comb begin
		st_d       = st_q;
		pos_d      = pos_q;
		blank_d    = blank_q;
		tach_d     = tach_q;
		tach_cnt_d = tach_cnt_q;
		load       = 1'b0;
		case (st_q)
			CBL_OPEN: begin
				// RULE3 transparent until a change
				// RULE1 closed while tach high
				if (hall_now != pos_q && !tach_q) begin
					load    = 1'b1;
					pos_d   = hall_now;
					blank_d = 2'h0;
					st_d    = CBL_BLANK;
				end
			end
			CBL_BLANK: begin
				// RULE4 hold for two ticks
				// RULE13 counts on the tick
				if (pwm_tick) begin
					if (blank_q == `CBL_BLANK_TICKS - 2'h1) begin
						st_d = CBL_HOLD;
					end else begin
						blank_d = blank_q + 2'h1;
					end
				end
			end
			CBL_HOLD: begin
				// RULE1 wait for tach low
				if (!tach_q) begin
					st_d = CBL_OPEN;
				end
			end
			default: begin
				st_d = CBL_OPEN;
			end
		endcase
		// RULE9 tach pulse with each load while brake is off
		if (load) begin
			tach_d     = 1'b1;
			tach_cnt_d = tach_w_q;
		end else if (tach_q) begin
			if (tach_cnt_q > 16'h0001) begin
				tach_cnt_d = tach_cnt_q - 16'h0001;
			end else begin
				tach_d     = 1'b0;
				tach_cnt_d = 16'h0000;
			end
		end
		// RULE12 brake stops the tach
		if (brake) begin
			tach_d     = 1'b0;
			tach_cnt_d = 16'h0000;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q       <= CBL_OPEN;
			pos_q      <= 3'h0;
			blank_q    <= 2'h0;
			tach_q     <= 1'b0;
			tach_cnt_q <= 16'h0000;
		end else begin
			st_q       <= st_d;
			pos_q      <= pos_d;
			blank_q    <= blank_d;
			tach_q     <= tach_d;
			tach_cnt_q <= tach_cnt_d;
		end
	end

	assign tach_pulse = tach_q;

	// commutation decode; bit 0 is phase a
	function automatic cbl_drive_t decode(input logic dir,
		input logic [2:0] h);
		cbl_drive_t d;
		d = '0;
		// RULE10 one low and one high per valid code
		case ({dir, h[0], h[1], h[2]})
			4'h9: d = '{hi: 3'h1, lo: 3'h2};
			4'hb: d = '{hi: 3'h1, lo: 3'h4};
			4'ha: d = '{hi: 3'h2, lo: 3'h4};
			4'he: d = '{hi: 3'h2, lo: 3'h1};
			4'hc: d = '{hi: 3'h4, lo: 3'h1};
			4'hd: d = '{hi: 3'h4, lo: 3'h2};
			4'h5: d = '{hi: 3'h2, lo: 3'h4};
			4'h4: d = '{hi: 3'h1, lo: 3'h4};
			4'h6: d = '{hi: 3'h1, lo: 3'h2};
			4'h2: d = '{hi: 3'h4, lo: 3'h2};
			4'h3: d = '{hi: 3'h4, lo: 3'h1};
			4'h1: d = '{hi: 3'h2, lo: 3'h1};
			default: d = '0;
		endcase
		return d;
	endfunction

	cbl_drive_t want;
	cbl_drive_t dec;

	always_comb begin
		dec = decode(ctrl_q.dir, pos_q);
		// RULE2 lockout forces all off
		if (uvlo || ctrl_q.coast) begin
			want = '0;
		// RULE12 brake: low follows pwm_on, high off
		end else if (brake) begin
			want.hi = 3'h0;
			want.lo = {3{pwm_on}};
		end else begin
			// RULE11 quadrant select gating
			want.lo = dec.lo & {3{pwm_on}};
			want.hi = ctrl_q.quad ? (dec.hi & {3{pwm_on}}) : dec.hi;
		end
	end

	// lockout pairs, one per phase
	logic [2:0] hi_on, lo_on, hi_lock, lo_lock, hi_pin, lo_pin;

	generate
		for (genvar p = 0; p < 3; p++) begin : g_phase
			// RULE7 low side wins a tie
			cbl_lockout #(.ACTIVE_LOW(1'b1)) u_hi (
				.aclk     (aclk),
				.aresetn  (aresetn),
				.pwm_tick (pwm_tick),
				.want     (want.hi[p]),
				.block    (lo_lock[p] | want.lo[p]),
				.drive_on (hi_on[p]),
				.lock     (hi_lock[p]),
				.pin_q    (hi_pin[p])
			);
			cbl_lockout #(.ACTIVE_LOW(1'b0)) u_lo (
				.aclk     (aclk),
				.aresetn  (aresetn),
				.pwm_tick (pwm_tick),
				.want     (want.lo[p]),
				.block    (hi_lock[p]),
				.drive_on (lo_on[p]),
				.lock     (lo_lock[p]),
				.pin_q    (lo_pin[p])
			);
		end
	endgenerate

	assign low_side_drive_a    = lo_pin[0];
	assign low_side_drive_b    = lo_pin[1];
	assign low_side_drive_c    = lo_pin[2];
	assign high_side_drive_a_n = hi_pin[0];
	assign high_side_drive_b_n = hi_pin[1];
	assign high_side_drive_c_n = hi_pin[2];

	// AXI4-Lite slave, one write and one read at a time
	logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
	logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [3:0]  waddr_q, waddr_d;
	logic        wmap_q, wmap_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        arr_q, arr_d, rv_q, rv_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;
	logic [31:0] status;

	assign status = {14'h0, hi_on, lo_on, hi_lock, lo_lock,
		st_q != CBL_OPEN, uvlo, tach_q, pos_q};

	always_comb begin
		awr_d    = awr_q;
		wr_d     = wr_q;
		bv_d     = bv_q;
		aw_got_d = aw_got_q;
		w_got_d  = w_got_q;
		waddr_d  = waddr_q;
		wmap_d   = wmap_q;
		wdata_d  = wdata_q;
		wstrb_d  = wstrb_q;
		bresp_d  = bresp_q;
		ctrl_d   = ctrl_q;
		tach_w_d = tach_w_q;
		if (!aw_got_q && !bv_q) begin
			awr_d = 1'b1;
		end
		if (!w_got_q && !bv_q) begin
			wr_d = 1'b1;
		end
		if (s_axi_awvalid && awr_q) begin
			awr_d    = 1'b0;
			aw_got_d = 1'b1;
			waddr_d  = s_axi_awaddr[3:0];
			wmap_d   = s_axi_awaddr[31:4] == 28'h0;
		end
		if (s_axi_wvalid && wr_q) begin
			wr_d    = 1'b0;
			w_got_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (aw_got_q && w_got_q) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bv_d     = 1'b1;
			bresp_d  = `CBL_RESP_SLVERR;
			if (wmap_q) begin
				case (waddr_q)
					`CBL_ADDR_CTRL: begin
						bresp_d = `CBL_RESP_OKAY;
						if (wstrb_q[0]) begin
							ctrl_d = wdata_q[3:0];
						end
					end
					`CBL_ADDR_TACH_WIDTH: begin
						bresp_d = `CBL_RESP_OKAY;
						if (wstrb_q[0]) begin
							tach_w_d[7:0] = wdata_q[7:0];
						end
						if (wstrb_q[1]) begin
							tach_w_d[15:8] = wdata_q[15:8];
						end
					end
					`CBL_ADDR_STATUS: begin
						bresp_d = `CBL_RESP_OKAY;
					end
					default: begin
						bresp_d = `CBL_RESP_SLVERR;
					end
				endcase
			end
		end
		if (bv_q && s_axi_bready) begin
			bv_d = 1'b0;
		end
	end

	always_comb begin
		arr_d   = arr_q;
		rv_d    = rv_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (!rv_q) begin
			arr_d = 1'b1;
		end
		if (s_axi_arvalid && arr_q) begin
			arr_d   = 1'b0;
			rv_d    = 1'b1;
			rdata_d = 32'h0;
			rresp_d = `CBL_RESP_SLVERR;
			if (s_axi_araddr[31:4] == 28'h0) begin
				case (s_axi_araddr[3:0])
					`CBL_ADDR_CTRL: begin
						rdata_d = {28'h0, ctrl_q};
						rresp_d = `CBL_RESP_OKAY;
					end
					`CBL_ADDR_TACH_WIDTH: begin
						rdata_d = {16'h0, tach_w_q};
						rresp_d = `CBL_RESP_OKAY;
					end
					`CBL_ADDR_STATUS: begin
						rdata_d = status;
						rresp_d = `CBL_RESP_OKAY;
					end
					default: begin
						rresp_d = `CBL_RESP_SLVERR;
					end
				endcase
			end
		end
		if (rv_q && s_axi_rready) begin
			rv_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awr_q    <= 1'b0;
			wr_q     <= 1'b0;
			bv_q     <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			waddr_q  <= 4'h0;
			wmap_q   <= 1'b0;
			wdata_q  <= 32'h0;
			wstrb_q  <= 4'h0;
			bresp_q  <= 2'h0;
			ctrl_q   <= `CBL_CTRL_RESET;
			tach_w_q <= `CBL_TACH_WIDTH_RESET;
			arr_q    <= 1'b0;
			rv_q     <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= 2'h0;
		end else begin
			awr_q    <= awr_d;
			wr_q     <= wr_d;
			bv_q     <= bv_d;
			aw_got_q <= aw_got_d;
			w_got_q  <= w_got_d;
			waddr_q  <= waddr_d;
			wmap_q   <= wmap_d;
			wdata_q  <= wdata_d;
			wstrb_q  <= wstrb_d;
			bresp_q  <= bresp_d;
			ctrl_q   <= ctrl_d;
			tach_w_q <= tach_w_d;
			arr_q    <= arr_d;
			rv_q     <= rv_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end

	assign s_axi_awready = awr_q;
	assign s_axi_wready  = wr_q;
	assign s_axi_bvalid  = bv_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid  = rv_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

endmodule

//--- cbl_cfg.svh
// Contract
// RULE1 - While the tachometer pulse is high, the position latches stay closed.
// RULE2 - While under-voltage lockout is active, all six drive outputs are off.
// RULE3 - The position latches are transparent until an input change is seen.
// RULE4 - After closing, the latches hold for two PWM oscillator ticks.
// RULE5 - Each of the six drivers has a lockout flop, set when it turns on.
// RULE6 - A lockout flop clears two PWM ticks after its driver turned off.
// RULE7 - A set lockout flop blocks the opposing driver of the same phase.
// RULE8 - For average current sensing the outside selects four-quadrant mode.
// RULE9 - A position change loads the latches and starts a tachometer pulse.
// RULE10 - Each valid code turns on one low and one high driver; 000/111 none.
// RULE11 - Quadrant low gates only low drivers by PWM; high gates all drivers.
// RULE12 - Brake turns high drivers off, low drivers on, and stops the tach. The code turns the low drivers on only while pwm_on is high.
// RULE13 - The PWM oscillator arrives as a one-cycle tick that drives counts.
`ifndef CBL_CFG_SVH
`define CBL_CFG_SVH

`define CBL_ADDR_CTRL        4'h0
`define CBL_ADDR_TACH_WIDTH  4'h4
`define CBL_ADDR_STATUS      4'h8

`define CBL_CTRL_DIR_BIT     0
`define CBL_CTRL_QUAD_BIT    1
`define CBL_CTRL_BRAKE_BIT   2
`define CBL_CTRL_COAST_BIT   3

`define CBL_CTRL_RESET       4'h0
`define CBL_TACH_WIDTH_RESET 16'h00c8

`define CBL_BLANK_TICKS      2'h2
`define CBL_LOCK_TICKS       2'h2

`define CBL_RESP_OKAY        2'h0
`define CBL_RESP_SLVERR      2'h2

`endif

//--- cbl_pkg.sv
package cbl_pkg;

	typedef struct packed {
		logic coast;
		logic brake;
		logic quad;
		logic dir;
	} cbl_ctrl_t;

	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} cbl_drive_t;

	typedef enum logic [1:0] {
		CBL_OPEN  = 2'h0,
		CBL_BLANK = 2'h1,
		CBL_HOLD  = 2'h3
	} cbl_latch_st_t;

endpackage

//--- cbl_lockout.sv
`include "cbl_cfg.svh"

module cbl_lockout #(
	parameter bit ACTIVE_LOW = 1'b0
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pwm_tick,
	input  wire logic want,
	input  wire logic block,
	output logic      drive_on,
	output logic      lock,
	output logic      pin_q
);

	logic       on_q, on_d;
	logic       lock_q, lock_d;
	logic [1:0] cnt_q, cnt_d;
	logic       pin_d;

	always_comb begin
		// RULE7 opposing lock blocks
		on_d   = want & ~block;
		lock_d = lock_q;
		cnt_d  = cnt_q;
		// RULE5 set on turn-on
		if (on_d) begin
			lock_d = 1'b1;
			cnt_d  = 2'h0;
		// RULE6 clear after two ticks
		end else if (lock_q && pwm_tick) begin
			if (cnt_q == `CBL_LOCK_TICKS - 2'h1) begin
				lock_d = 1'b0;
				cnt_d  = 2'h0;
			end else begin
				cnt_d = cnt_q + 2'h1;
			end
		end
		pin_d = ACTIVE_LOW ? ~on_d : on_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_q   <= 1'b0;
			lock_q <= 1'b0;
			cnt_q  <= 2'h0;
			pin_q  <= ACTIVE_LOW;
		end else begin
			on_q   <= on_d;
			lock_q <= lock_d;
			cnt_q  <= cnt_d;
			pin_q  <= pin_d;
		end
	end

	assign drive_on = on_q;
	assign lock     = lock_q;

endmodule

//--- cbl_assertions.sv
module cbl_assertions (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic brake_timing_node,
	input  wire logic supply_low,
	input  wire logic pwm_tick,
	input  wire logic pwm_on,
	input  wire logic low_side_drive_a,
	input  wire logic low_side_drive_b,
	input  wire logic low_side_drive_c,
	input  wire logic high_side_drive_a_n,
	input  wire logic high_side_drive_b_n,
	input  wire logic high_side_drive_c_n,
	input  wire logic tach_pulse
);
	logic [2:0] lo, hi, ok_lo, ok_hi;
	logic [1:0] cl_d [3], cl_q [3], ch_d [3], ch_q [3];
	assign lo = {low_side_drive_c, low_side_drive_b, low_side_drive_a};
	assign hi = ~{high_side_drive_c_n, high_side_drive_b_n,
		high_side_drive_a_n};
	// ticks since a driver went off, the tick of its last on cycle included
	function automatic logic [1:0] nxt(logic on, logic [1:0] c, logic t);
		if (on)
			return {1'b0, t};
		return (c == 2'h2) ? c : c + {1'b0, t};
	endfunction
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			cl_d[i] = nxt(lo[i], cl_q[i], pwm_tick);
			ch_d[i] = nxt(hi[i], ch_q[i], pwm_tick);
			ok_lo[i] = cl_q[i] == 2'h2;
			ok_hi[i] = ch_q[i] == 2'h2;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cl_q <= '{3{2'h2}};
			ch_q <= '{3{2'h2}};
		end else begin
			cl_q <= cl_d;
			ch_q <= ch_d;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence uvlo_held;
		supply_low [*8];
	endsequence
	sequence brake_held;
		!brake_timing_node [*8];
	endsequence
	chk_no_overlap: assert property ((lo & hi) == 3'h0)
		else $error("both drivers of one phase on");
	chk_lo_dead: assert property (
		(lo & ~$past(lo) & ~$past(ok_hi)) == 3'h0)
		else $error("low side on without dead time");
	chk_hi_dead: assert property (
		(hi & ~$past(hi) & ~$past(ok_lo)) == 3'h0)
		else $error("high side on without dead time");
	chk_one_high: assert property ($onehot0(hi))
		else $error("more than one high side on");
	chk_lo_pwm: assert property (lo != 3'h0 |-> $past(pwm_on))
		else $error("low side on while chop off");
	chk_uvlo_off: assert property (
		uvlo_held |-> lo == 3'h0 && hi == 3'h0)
		else $error("drive on in supply lockout");
	chk_brake_hi: assert property (brake_held |-> hi == 3'h0)
		else $error("high side on in brake");
	chk_brake_tach: assert property (brake_held |-> !tach_pulse)
		else $error("tach pulse in brake");
endmodule

bind cbl_top cbl_assertions cbl_assertions_inst (.aclk, .aresetn,
	.brake_timing_node, .supply_low, .pwm_tick, .pwm_on, .low_side_drive_a,
	.low_side_drive_b, .low_side_drive_c, .high_side_drive_a_n,
	.high_side_drive_b_n, .high_side_drive_c_n, .tach_pulse);

//--- cbl_partner.sv
module cbl_partner (
	input  wire logic       aclk,
	input  wire logic [2:0] target,
	input  wire logic       bounce,
	input  wire logic       low_side_drive_a,
	input  wire logic       low_side_drive_b,
	input  wire logic       low_side_drive_c,
	input  wire logic       high_side_drive_a_n,
	input  wire logic       high_side_drive_b_n,
	input  wire logic       high_side_drive_c_n,
	output logic            hall_sense_a,
	output logic            hall_sense_b,
	output logic            hall_sense_c,
	output logic [7:0]      shorts
);
	logic [2:0] cur_q = 3'h0;
	logic [2:0] prev_q = 3'h0;
	logic [3:0] age_q = 4'h0;
	logic [7:0] short_q = 8'h00;
	// a bouncing sensor falls back to the old code for four cycles
	assign {hall_sense_a, hall_sense_b, hall_sense_c} =
		(bounce && age_q[3] && !age_q[2]) ? prev_q : cur_q;
	assign shorts = short_q;
	always_ff @(posedge aclk) begin
		age_q <= (target != cur_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hc};
		if (target != cur_q) begin
			prev_q <= cur_q;
			cur_q <= target;
		end
		// power stage counts cycles of shoot-through
		short_q <= short_q + {7'h00, (low_side_drive_a & !high_side_drive_a_n) |
			(low_side_drive_b & !high_side_drive_b_n) |
			(low_side_drive_c & !high_side_drive_c_n)};
	end
endmodule

//--- tb_commutation_blanking_lockout.sv
`include "cbl_cfg.svh"

module tb_commutation_blanking_lockout;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] TW = 16'h0014;
	logic        aclk, aresetn, brake_timing_node, supply_low, pwm_tick;
	logic        pwm_on, hall_sense_a, hall_sense_b, hall_sense_c, bounce;
	logic        low_side_drive_a, low_side_drive_b, low_side_drive_c, tp_q;
	logic        high_side_drive_a_n, high_side_drive_b_n, high_side_drive_c_n;
	logic        tach_pulse, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [2:0]  target, tc;
	logic [7:0]  shorts;
	logic [5:0]  got;
	int          mismatches, n_checks, seed, rises, width, run, idx;
	logic [2:0]  seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	assign got = {~high_side_drive_c_n, ~high_side_drive_b_n,
		~high_side_drive_a_n, low_side_drive_c, low_side_drive_b,
		low_side_drive_a};
	cbl_top cbl_top_inst (.*);
	cbl_partner cbl_partner_inst (.*);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		tc <= tc + 3'h1;
		pwm_tick <= tc == 3'h7;
	end
	always @(posedge aclk) begin
		tp_q <= tach_pulse;
		if (tach_pulse && !tp_q)
			rises <= rises + 1;
		run <= tach_pulse ? run + 1 : 0;
		if (!tach_pulse && tp_q)
			width <= run;
	end
	// drive codes {hi c..a, lo c..a}; reverse direction inverts every bit of the code
	function automatic logic [5:0] expd(logic [2:0] c, logic d);
		case (d ? c : ~c)
			3'h1: return 6'h0a;
			3'h3: return 6'h0c;
			3'h2: return 6'h14;
			3'h6: return 6'h11;
			3'h4: return 6'h21;
			3'h5: return 6'h22;
			default: return 6'h00;
		endcase
	endfunction
	task chk(input logic [39:0] g, input logic [39:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [31:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task step(input logic [2:0] c);
		target <= c;
		repeat (60) @(posedge aclk);
	endtask
	task print_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100us;
		mismatches++;
		print_verdict;
	end
	initial begin
		{aresetn, supply_low, pwm_tick, pwm_on, bounce, tc, target} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, rises, width, run, tp_q} = '0;
		brake_timing_node = 1'b1;
		s_axi_wstrb = 4'hf;
		seed = 16;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`CBL_ADDR_TACH_WIDTH);
		chk(rdat, `CBL_TACH_WIDTH_RESET);
		rd(32'h0000_0010);
		chk({rdat, resp}, {32'h0, `CBL_RESP_SLVERR});
		wr(`CBL_ADDR_TACH_WIDTH, {16'h0, TW});
		chk(resp, `CBL_RESP_OKAY);
		wr(`CBL_ADDR_STATUS, 32'hffff_ffff);
		chk(resp, `CBL_RESP_OKAY);
		wr(32'h0000_000c, 32'h0);
		chk(resp, `CBL_RESP_SLVERR);
		rd(`CBL_ADDR_TACH_WIDTH);
		chk({rdat, resp}, {16'h0, TW, `CBL_RESP_OKAY});
		pwm_on <= 1'b1;
		for (int d = 1; d >= 0; d--) begin
			wr(`CBL_ADDR_CTRL, d);
			for (int k = 0; k < 6; k++) begin
				rises = 0;
				step(seq[k]);
				chk(got, expd(seq[k], d[0]));
				chk(rises, 1);
				chk(width, TW);
			end
		end
		step(3'h7);
		chk(got, 6'h00);
		step(3'h5);
		step(3'h4);
		step(3'h0);
		chk(got, 6'h00);
		bounce <= 1'b1;
		rises = 0;
		step(3'h4);
		chk(rises, 1);
		rd(`CBL_ADDR_STATUS);
		chk(rdat[2:0], 3'h1);
		bounce <= 1'b0;
		// long pulse: a change after blanking but inside the pulse is held off
		wr(`CBL_ADDR_TACH_WIDTH, 32'h0000_0064);
		rises = 0;
		target <= 3'h6;
		repeat (40) @(posedge aclk);
		target <= 3'h4;
		repeat (20) @(posedge aclk);
		target <= 3'h6;
		repeat (10) @(posedge aclk);
		rd(`CBL_ADDR_STATUS);
		chk({rdat[5:0], rises[1:0]}, {6'h2b, 2'h1});
		wr(`CBL_ADDR_TACH_WIDTH, {16'h0, TW});
		step(3'h4);
		rises = 0;
		target <= 3'h6;
		repeat (6) @(posedge aclk);
		step(3'h2);
		chk(rises, 2);
		chk(got, expd(3'h2, 1'b0));
		pwm_on <= 1'b0;
		repeat (10) @(posedge aclk);
		chk(got, expd(3'h2, 1'b0) & 6'h38);
		// four-quadrant chopping, as average sensing needs
		wr(`CBL_ADDR_CTRL, 32'h2);
		repeat (10) @(posedge aclk);
		chk(got, 6'h00);
		pwm_on <= 1'b1;
		brake_timing_node <= 1'b0;
		rises = 0;
		step(3'h3);
		chk({tach_pulse, got, rises[1:0]}, {1'b0, 6'h07, 2'h0});
		brake_timing_node <= 1'b1;
		supply_low <= 1'b1;
		repeat (20) @(posedge aclk);
		chk(got, 6'h00);
		supply_low <= 1'b0;
		repeat (30) @(posedge aclk);
		chk(got, expd(3'h3, 1'b0));
		wr(`CBL_ADDR_CTRL, 32'ha);
		repeat (4) @(posedge aclk);
		chk(got, 6'h00);
		wr(`CBL_ADDR_CTRL, 32'h6);
		repeat (30) @(posedge aclk);
		chk({tach_pulse, got}, {1'b0, 6'h07});
		wr(`CBL_ADDR_CTRL, 32'h2);
		idx = 1;
		repeat (400) begin
			@(posedge aclk);
			pwm_on <= 1'($random(seed));
			if (($random(seed) & 31) == 0) begin
				idx = (idx + ((($random(seed) & 1) != 0) ? 5 : 1)) % 6;
				target <= seq[idx];
			end
		end
		repeat (60) @(posedge aclk);
		chk(shorts, 8'h00);
		print_verdict;
	end
endmodule
